// [logic/difd_pkg.sv]
package difd_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [7:0] DIFD_DRV1_OFS   = 8'h00;
   localparam logic [7:0] DIFD_BRK1_OFS   = 8'h04;
   localparam logic [7:0] DIFD_DRV2_OFS   = 8'h08;
   localparam logic [7:0] DIFD_BRK2_OFS   = 8'h0C;
   localparam logic [7:0] DIFD_VEC_OFS    = 8'h10;
   localparam logic [7:0] DIFD_BOOST_OFS  = 8'h14;
   localparam logic [7:0] DIFD_SLIP_OFS   = 8'h18;
   localparam logic [7:0] DIFD_FCMD1_OFS  = 8'h1C;
   localparam logic [7:0] DIFD_FCMD2_OFS  = 8'h20;
   localparam logic [7:0] DIFD_STAT_OFS   = 8'h24;
   localparam logic [7:0] DIFD_ACT_OFS    = 8'h28;
   localparam logic [7:0] DIFD_TRQ_OFS    = 8'h2C;
   localparam logic [7:0] DIFD_OUTF_OFS   = 8'h30;
   localparam logic [7:0] DIFD_TFUNC_OFS  = 8'h40;  // terminal k at 0x40 + 4*(k-1)
   localparam logic [7:0] DIFD_PRESET_OFS = 8'h80;  // step k at 0x80 + 4*k, k = 1..15
   // status register field positions
   localparam int DIFD_ST_STEP_LSB = 0;
   localparam int DIFD_ST_PRESET   = 4;
   localparam int DIFD_ST_RAMP_LSB = 5;
   localparam int DIFD_ST_ACT32    = 7;
   localparam int DIFD_ST_SLIPON   = 8;
   localparam int DIFD_ST_LIMIT    = 9;
   localparam int DIFD_ST_OVAVOID  = 10;
   // torque limit setting values, in percent
   localparam logic [15:0] DIFD_LIM_MIN  = 16'h0014;  // 20 %
   localparam logic [15:0] DIFD_LIM_MAX  = 16'h00C8;  // 200 %
   localparam logic [15:0] DIFD_LIM_OFF  = 16'h03E7;  // 999
   localparam logic [15:0] DIFD_LIM_OVAV = 16'h0000;  // braking only
   // preset frequency ceiling, 0.01 Hz units (400.00 Hz)
   localparam logic [15:0] DIFD_FREQ_MAX = 16'h9C40;
   // function codes that the decode logic looks at itself
   localparam int DIFD_NFUNC      = 33;
   localparam int DIFD_FN_RAMP_LO = 4;
   localparam int DIFD_FN_RAMP_HI = 5;
   localparam int DIFD_FN_FAULT   = 9;
   localparam int DIFD_FN_FSRC    = 11;
   localparam int DIFD_FN_TLSEL   = 14;
   // reset values
   localparam logic [15:0] DIFD_LIM_RST   = DIFD_LIM_OFF;
   localparam logic        DIFD_VEC_RST   = 1'b0;
   localparam logic [15:0] DIFD_BOOST_RST = 16'h0000;
   localparam logic [15:0] DIFD_SLIP_RST  = 16'h0000;
   localparam logic [15:0] DIFD_FCMD_RST  = 16'h0000;
   localparam logic [7:0]  DIFD_TFUNC_RST = 8'h00;   // terminal k resets to code k-1
   // torque estimate scaling: loss term and final percent shift
   localparam int DIFD_LOSS_SHIFT = 8;
   localparam int DIFD_TRQ_SHIFT  = 8;
   // slip amount applied for a standard motor under vector control when the stored amount is zero
   localparam logic [15:0] DIFD_STD_SLIP = 16'h0010;
endpackage

// [logic/difd_preset_mem.sv]
module difd_preset_mem
   import difd_pkg::*;
#(
   parameter int W = 16,
   parameter int D = 16
) (
   input  wire logic                 clk_i,
   input  wire logic                 we_i,
   input  wire logic [$clog2(D)-1:0] waddr_i,
   input  wire logic [W-1:0]         wdata_i,
   input  wire logic [$clog2(D)-1:0] ra_addr_i,
   output logic      [W-1:0]         ra_data_o,
   input  wire logic [$clog2(D)-1:0] rb_addr_i,
   output logic      [W-1:0]         rb_data_o
);
   logic [W-1:0] mem [D];  // preset table, one word per step

   // one write port, two registered read ports (decoder and bus)
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      ra_data_o <= mem[ra_addr_i];
      rb_data_o <= mem[rb_addr_i];
   end
endmodule

// [logic/difd_top.sv]
module difd_top
   import difd_pkg::*;
#(
   parameter int N_TERM = 9
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic [N_TERM-1:0]  term_i,
   input  wire logic               dcbus_high_i,
   input  wire logic [15:0]        out_voltage_i,
   input  wire logic signed [15:0] out_current_i,
   input  wire logic [15:0]        prim_res_i,
   input  wire logic               ramp_tick_i,
   output logic [DIFD_NFUNC-1:0]   func_active_o,
   output logic [3:0]              step_o,
   output logic                    preset_sel_o,
   output logic [15:0]             freq_cmd_o,
   output logic [1:0]              ramp_set_o,
   output logic [15:0]             drv_limit_o,
   output logic                    drv_limit_en_o,
   output logic [15:0]             brk_limit_o,
   output logic                    brk_limit_en_o,
   output logic                    ov_avoid_o,
   output logic                    limiting_o,
   output logic [15:0]             out_freq_o,
   output logic                    vec_enable_o,
   output logic [15:0]             eff_boost_o,
   output logic                    slip_comp_on_o,
   output logic [15:0]             eff_slip_o,
   output logic signed [15:0]      torque_est_o
);
   if (N_TERM < 1 || N_TERM > 16) begin : g_chk
      $error("difd_top: N_TERM must lie in 1..16");
   end

   typedef struct packed {
      logic                       ack;      // bus answer
      logic                       pend;     // request seen, answer next edge
      logic [31:0]                dat;      // read data
      logic [15:0]                drv1;     // first pair of limits
      logic [15:0]                brk1;
      logic [15:0]                drv2;     // second pair of limits
      logic [15:0]                brk2;
      logic                       vec;      // vector control setting
      logic [15:0]                boost;    // stored boost
      logic [15:0]                slip;     // stored slip amount
      logic [15:0]                fcmd1;    // primary frequency command
      logic [15:0]                fcmd2;    // secondary frequency command
      logic [N_TERM-1:0][7:0]     tfunc;    // per-terminal function code
      logic [N_TERM-1:0]          sync1;    // terminal synchroniser, stage 1
      logic [N_TERM-1:0]          sync2;    // terminal synchroniser, stage 2
      logic                       dcb1;     // bus-high synchroniser
      logic                       dcb2;
      logic [DIFD_NFUNC-1:0]      act;      // decoded functions
      logic [3:0]                 step;
      logic                       psel;
      logic                       psel_d;   // psel one cycle later, holds the switch to the preset back a cycle
      logic [15:0]                freq;
      logic [1:0]                 ramp;
      logic [15:0]                dlim;
      logic                       den;
      logic [15:0]                blim;
      logic                       ben;
      logic                       ovav;
      logic                       lact;
      logic [15:0]                outf;
      logic signed [15:0]         est;
      logic [15:0]                eboost;
      logic                       slipon;
      logic [15:0]                eslip;
   } difd_state_t;

   difd_state_t cur;       // registered state
   difd_state_t next_cur;  // combinational copy

   logic [15:0] pa_data;   // preset for current step
   logic [15:0] pb_data;   // preset for bus read
   logic        mem_we;

   // byte-lane merge of a 16-bit register, honouring wishbone sel
   function automatic logic [15:0] lane16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  sel);
      lane16 = old;
      if (sel[0]) lane16[7:0] = d[7:0];
      if (sel[1]) lane16[15:8] = d[15:8];
   endfunction

   // terminals whose code equals the given function
   function automatic logic [N_TERM-1:0] terms_for(input logic [N_TERM-1:0][7:0] tf,
                                                   input int code);
      terms_for = '0;
      for (int k = 0; k < N_TERM; k++) begin
         terms_for[k] = (tf[k] == 8'(code));
      end
   endfunction

   // out-of-range settings are pulled to the nearest legal value
   function automatic logic [15:0] clamp_lim(input logic [15:0] v);
      if (v < DIFD_LIM_MIN)
         clamp_lim = DIFD_LIM_MIN;
      else if (v > DIFD_LIM_MAX)
         clamp_lim = DIFD_LIM_MAX;
      else
         clamp_lim = v;
   endfunction

   logic [DIFD_NFUNC-1:0] fn_on;  // raw decode of synchronised terminals

   // one decoder per function code: OR over every terminal carrying it
   for (genvar f = 0; f < DIFD_NFUNC; f++) begin : g_fn
      logic [N_TERM-1:0] hits;
      assign hits = terms_for(cur.tfunc, f);
      if (f == DIFD_FN_FAULT) begin : g_flt
         // fault input is break-active; unassigned means no fault
         assign fn_on[f] = |(hits & ~cur.sync2);
      end else begin : g_std
         assign fn_on[f] = |(hits & cur.sync2);
      end
   end

   assign mem_we = cur.pend && !cur.ack && wb_we_i && wb_adr_i[7] && (wb_adr_i[5:2] != 4'h0)
                   && (wb_sel_i[1:0] == 2'b11);

   difd_preset_mem #(
      .W (16),
      .D (16)
   ) u_mem (
      .clk_i     (clk_i),
      .we_i      (mem_we),
      .waddr_i   (wb_adr_i[5:2]),
      .wdata_i   ((wb_dat_i[15:0] > DIFD_FREQ_MAX) ? DIFD_FREQ_MAX : wb_dat_i[15:0]),
      .ra_addr_i (cur.step),
      .ra_data_o (pa_data),
      .rb_addr_i (wb_adr_i[5:2]),
      .rb_data_o (pb_data)
   );

   // torque estimate: input power less copper loss, in percent scale
   logic signed [47:0] pwr;
   logic signed [47:0] loss;
   logic signed [47:0] agap;
   logic signed [47:0] scaled;
   logic signed [15:0] est_sat;
   always_comb begin
      pwr    = 48'(signed'({1'b0, out_voltage_i}) * out_current_i);
      loss   = 48'(signed'(48'((out_current_i * out_current_i) >>> DIFD_LOSS_SHIFT))
                  * signed'({1'b0, prim_res_i}));
      agap   = pwr - loss;
      scaled = agap >>> DIFD_TRQ_SHIFT;
      if (scaled > 48'sd32767)
         est_sat = 16'sh7FFF;
      else if (scaled < -48'sd32768)
         est_sat = -16'sh8000;
      else
         est_sat = scaled[15:0];
   end

   // next-state logic for the whole block
   logic [15:0] dsel;
   logic [15:0] bsel;
   logic [15:0] mag;
   logic        take;
   always_comb begin
      next_cur = cur;
      dsel     = 16'h0000;
      bsel     = 16'h0000;
      mag      = 16'h0000;
      take     = wb_cyc_i && wb_stb_i && !cur.pend && !cur.ack;

      // pins pass two flops before any decoding
      next_cur.sync1 = term_i;
      next_cur.sync2 = cur.sync1;
      next_cur.dcb1  = dcbus_high_i;
      next_cur.dcb2  = cur.dcb1;
      next_cur.act   = fn_on;

      // step number and frequency source
      next_cur.step   = cur.act[3:0];
      next_cur.psel   = cur.step != 4'h0;
      next_cur.psel_d = cur.psel;
      // psel is in step with the preset read word; psel_d only holds the switch back a cycle
      if (cur.psel && cur.psel_d)
         next_cur.freq = pa_data;
      else if (cur.act[DIFD_FN_FSRC])
         next_cur.freq = cur.fcmd2;
      else
         next_cur.freq = cur.fcmd1;
      // bit 0 of the ramp set is the low select, bit 1 the high
      next_cur.ramp = {cur.act[DIFD_FN_RAMP_HI], cur.act[DIFD_FN_RAMP_LO]};

      // limit pair selection and decoding
      dsel = cur.act[DIFD_FN_TLSEL] ? cur.drv2 : cur.drv1;
      bsel = cur.act[DIFD_FN_TLSEL] ? cur.brk2 : cur.brk1;
      next_cur.den  = dsel != DIFD_LIM_OFF;
      next_cur.dlim = clamp_lim(dsel);
      next_cur.ovav = bsel == DIFD_LIM_OVAV;
      next_cur.ben  = (bsel != DIFD_LIM_OFF) && (bsel != DIFD_LIM_OVAV);
      next_cur.blim = clamp_lim(bsel);

      // vector control overrides of boost and slip compensation
      next_cur.eboost = cur.vec ? 16'h0000 : cur.boost;
      next_cur.slipon = cur.vec || (cur.slip != 16'h0000);
      next_cur.eslip  = (cur.vec && cur.slip == 16'h0000) ? DIFD_STD_SLIP : cur.slip;

      // frequency trim, one unit per ramp tick; limiting wins over the ramp,
      // so the ramp can take longer than set
      next_cur.est = est_sat;
      mag = cur.est[15] ? 16'(-cur.est) : 16'(cur.est);
      if (ramp_tick_i) begin
         if (cur.den && !cur.est[15] && mag > cur.dlim) begin
            next_cur.lact = 1'b1;
            if (cur.outf != 16'h0000) next_cur.outf = cur.outf - 16'h0001;
         end else if (cur.ovav && cur.dcb2) begin
            // regeneration is raising the bus: back off deceleration
            next_cur.lact = 1'b1;
            if (cur.outf < DIFD_FREQ_MAX) next_cur.outf = cur.outf + 16'h0001;
         end else if (cur.ben && cur.est[15] && mag > cur.blim) begin
            next_cur.lact = 1'b1;
            if (cur.outf < DIFD_FREQ_MAX) next_cur.outf = cur.outf + 16'h0001;
         end else begin
            next_cur.lact = 1'b0;
            if (cur.outf < cur.freq)
               next_cur.outf = cur.outf + 16'h0001;
            else if (cur.outf > cur.freq)
               next_cur.outf = cur.outf - 16'h0001;
         end
      end

      // wishbone: take, then answer one edge later with ack for one cycle
      next_cur.ack = 1'b0;
      if (take) begin
         next_cur.pend = 1'b1;
      end
      if (cur.pend) begin
         next_cur.pend = 1'b0;
         next_cur.ack  = 1'b1;
         next_cur.dat  = 32'h0000_0000;
         case (wb_adr_i)
            DIFD_DRV1_OFS:  next_cur.dat[15:0] = cur.drv1;
            DIFD_BRK1_OFS:  next_cur.dat[15:0] = cur.brk1;
            DIFD_DRV2_OFS:  next_cur.dat[15:0] = cur.drv2;
            DIFD_BRK2_OFS:  next_cur.dat[15:0] = cur.brk2;
            DIFD_VEC_OFS:   next_cur.dat[0]    = cur.vec;
            DIFD_BOOST_OFS: next_cur.dat[15:0] = cur.boost;
            DIFD_SLIP_OFS:  next_cur.dat[15:0] = cur.slip;
            DIFD_FCMD1_OFS: next_cur.dat[15:0] = cur.fcmd1;
            DIFD_FCMD2_OFS: next_cur.dat[15:0] = cur.fcmd2;
            DIFD_STAT_OFS: begin
               next_cur.dat[DIFD_ST_STEP_LSB +: 4] = cur.step;
               next_cur.dat[DIFD_ST_PRESET]        = cur.psel;
               next_cur.dat[DIFD_ST_RAMP_LSB +: 2] = cur.ramp;
               next_cur.dat[DIFD_ST_ACT32]         = cur.act[32];
               next_cur.dat[DIFD_ST_SLIPON]        = cur.slipon;
               next_cur.dat[DIFD_ST_LIMIT]         = cur.lact;
               next_cur.dat[DIFD_ST_OVAVOID]       = cur.ovav;
            end
            DIFD_ACT_OFS:   next_cur.dat       = cur.act[31:0];
            DIFD_TRQ_OFS:   next_cur.dat[15:0] = cur.est;
            DIFD_OUTF_OFS:  next_cur.dat[15:0] = cur.outf;
            default: begin
               if (wb_adr_i[7] && wb_adr_i[5:2] != 4'h0 && wb_adr_i[6] == 1'b0)
                  next_cur.dat[15:0] = pb_data;
               else if (wb_adr_i >= DIFD_TFUNC_OFS && wb_adr_i[7:6] == 2'b01
                        && 5'(wb_adr_i[5:2]) < 5'(N_TERM))
                  next_cur.dat[7:0] = cur.tfunc[wb_adr_i[5:2]];
            end
         endcase
         // writes land at the edge that raises ack; read-only and unmapped ignore them, except 0xC4-0xFF, which write the preset table like 0x84-0xBF
         if (wb_we_i) begin
            case (wb_adr_i)
               DIFD_DRV1_OFS:  next_cur.drv1  = lane16(cur.drv1, wb_dat_i, wb_sel_i);
               DIFD_BRK1_OFS:  next_cur.brk1  = lane16(cur.brk1, wb_dat_i, wb_sel_i);
               DIFD_DRV2_OFS:  next_cur.drv2  = lane16(cur.drv2, wb_dat_i, wb_sel_i);
               DIFD_BRK2_OFS:  next_cur.brk2  = lane16(cur.brk2, wb_dat_i, wb_sel_i);
               DIFD_VEC_OFS:   if (wb_sel_i[0]) next_cur.vec = wb_dat_i[0];
               DIFD_BOOST_OFS: next_cur.boost = lane16(cur.boost, wb_dat_i, wb_sel_i);
               DIFD_SLIP_OFS:  next_cur.slip  = lane16(cur.slip, wb_dat_i, wb_sel_i);
               DIFD_FCMD1_OFS: next_cur.fcmd1 = lane16(cur.fcmd1, wb_dat_i, wb_sel_i);
               DIFD_FCMD2_OFS: next_cur.fcmd2 = lane16(cur.fcmd2, wb_dat_i, wb_sel_i);
               default: begin
                  if (wb_adr_i[7:6] == 2'b01 && 5'(wb_adr_i[5:2]) < 5'(N_TERM) && wb_sel_i[0])
                     next_cur.tfunc[wb_adr_i[5:2]] = wb_dat_i[7:0];
               end
            endcase
         end
      end

      if (rst_i) begin
         next_cur       = '0;
         next_cur.drv1  = DIFD_LIM_RST;
         next_cur.brk1  = DIFD_LIM_RST;
         next_cur.drv2  = DIFD_LIM_RST;
         next_cur.brk2  = DIFD_LIM_RST;
         next_cur.vec   = DIFD_VEC_RST;
         next_cur.boost = DIFD_BOOST_RST;
         next_cur.slip  = DIFD_SLIP_RST;
         next_cur.fcmd1 = DIFD_FCMD_RST;
         next_cur.fcmd2 = DIFD_FCMD_RST;
         next_cur.dlim  = DIFD_LIM_MAX;
         next_cur.blim  = DIFD_LIM_MAX;
         for (int k = 0; k < N_TERM; k++) begin
            next_cur.tfunc[k] = DIFD_TFUNC_RST + 8'(k);
         end
      end
   end

   // single state register, synchronous reset folded in above
   always_ff @(posedge clk_i) begin
      cur <= next_cur;
   end

   assign wb_dat_o       = cur.dat;
   assign wb_ack_o       = cur.ack;
   assign func_active_o  = cur.act;
   assign step_o         = cur.step;
   assign preset_sel_o   = cur.psel;
   assign freq_cmd_o     = cur.freq;
   assign ramp_set_o     = cur.ramp;
   assign drv_limit_o    = cur.dlim;
   assign drv_limit_en_o = cur.den;
   assign brk_limit_o    = cur.blim;
   assign brk_limit_en_o = cur.ben;
   assign ov_avoid_o     = cur.ovav;
   assign limiting_o     = cur.lact;
   assign out_freq_o     = cur.outf;
   assign vec_enable_o   = cur.vec;
   assign eff_boost_o    = cur.eboost;
   assign slip_comp_on_o = cur.slipon;
   assign eff_slip_o     = cur.eslip;
   assign torque_est_o   = cur.est;
endmodule

// [verification/difd_top_properties.sv]
module difd_top_properties
   import difd_pkg::*;
#(
   parameter int N_TERM = 9
) (
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_ack_o,
   input wire logic [DIFD_NFUNC-1:0] func_active_o,
   input wire logic [3:0]            step_o,
   input wire logic                  preset_sel_o,
   input wire logic [1:0]            ramp_set_o,
   input wire logic [15:0]           drv_limit_o,
   input wire logic [15:0]           brk_limit_o,
   input wire logic                  vec_enable_o,
   input wire logic [15:0]           eff_boost_o,
   input wire logic                  slip_comp_on_o,
   input wire logic                  ramp_tick_i,
   input wire logic                  limiting_o,
   input wire logic [15:0]           out_freq_o
);
   // one clock domain, so clocking and reset are declared once
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // bus answer is a single pulse and always has a request behind it
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
      else $error("ack without a request");
   ack_time_a: assert property ($rose(wb_cyc_i & wb_stb_i) |-> ##[1:3] wb_ack_o)
      else $error("ack late");
   // step number lags the decoded step inputs by one register stage
   step_sum_a: assert property (step_o == $past(func_active_o[3:0]))
      else $error("step not weighted sum");
   preset_sel_a: assert property (preset_sel_o == ($past(step_o) != 4'h0))
      else $error("preset select mismatch");
   ramp_pick_a: assert property (ramp_set_o == $past(func_active_o[5:4]))
      else $error("ramp set mismatch");
   drv_range_a: assert property (drv_limit_o >= DIFD_LIM_MIN &&
      drv_limit_o <= DIFD_LIM_MAX)
      else $error("driving limit out of range");
   brk_range_a: assert property (brk_limit_o >= DIFD_LIM_MIN &&
      brk_limit_o <= DIFD_LIM_MAX)
      else $error("braking limit out of range");
   vec_boost_a: assert property (vec_enable_o && $past(vec_enable_o) |->
      eff_boost_o == 16'h0000)
      else $error("boost not zero under vector control");
   vec_slip_a: assert property (vec_enable_o && $past(vec_enable_o) |-> slip_comp_on_o)
      else $error("slip comp off under vector control");
   // output frequency moves only on a tick, one unit at a time
   freq_tick_a: assert property ($changed(out_freq_o) |-> $past(ramp_tick_i))
      else $error("frequency moved without tick");
   freq_step_a: assert property ($changed(out_freq_o) |->
      (out_freq_o == $past(out_freq_o) + 16'h0001) || (out_freq_o + 16'h0001 == $past(out_freq_o)))
      else $error("frequency step larger than one");

   cover property (preset_sel_o && step_o == 4'hF);
   cover property (limiting_o);
   cover property (ramp_set_o == 2'h3);
endmodule

bind difd_top difd_top_properties #(.N_TERM(N_TERM)) i_difd_top_properties (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .func_active_o(func_active_o), .step_o(step_o),
   .preset_sel_o(preset_sel_o), .ramp_set_o(ramp_set_o), .drv_limit_o(drv_limit_o),
   .brk_limit_o(brk_limit_o), .vec_enable_o(vec_enable_o), .eff_boost_o(eff_boost_o),
   .slip_comp_on_o(slip_comp_on_o), .ramp_tick_i(ramp_tick_i),
   .limiting_o(limiting_o), .out_freq_o(out_freq_o));

// [verification/difd_far_side.sv]
module difd_far_side (
   input  wire logic               clk_i,
   input  wire logic               tick_en_i,
   input  wire logic               load_i,
   input  wire logic               bus_hi_i,
   input  wire logic [8:0]         contacts_i,
   output logic      [8:0]         term_o,
   output logic                    dcbus_high_o,
   output logic      [15:0]        out_voltage_o,
   output logic signed [15:0]      out_current_o,
   output logic      [15:0]        prim_res_o,
   output logic                    ramp_tick_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // contacts close straight onto the terminals
   assign term_o        = contacts_i;
   // bus raised on request, standing in for regeneration
   assign dcbus_high_o  = bus_hi_i;
   // heavy motoring load when asked, idle otherwise
   assign out_voltage_o = load_i ? 16'h0190 : 16'h0000;
   assign out_current_o = load_i ? 16'sh03E8 : 16'sh0000;
   assign prim_res_o    = 16'h0001;
   // ramp tick every other cycle, only while enabled
   always_ff @(posedge clk_i) begin
      ramp_tick_o <= tick_en_i & ~ramp_tick_o;
   end
endmodule

// [verification/test_drive_input_function_decode.sv]
module test_drive_input_function_decode import difd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_i, cyc, stb, we, ack, tick_en, load, hi;
   logic [7:0]  adr;
   logic [31:0] wdat, rdata, rdat;
   logic [8:0]  contacts, term;
   logic [DIFD_NFUNC-1:0] func;
   logic [3:0]  step;
   logic [1:0]  ramp;
   logic [15:0] freq, drv, brk, boost, slip, outf, volt, res;
   logic signed [15:0] cur, trq;
   logic psel, drv_en, brk_en, ovav, lim, vec, slip_on, bus_hi, tick;
   int n_errors, checks_done, cycles;

   difd_far_side i_difd_far_side (.clk_i(clk_i), .tick_en_i(tick_en), .load_i(load),
      .contacts_i(contacts), .term_o(term), .dcbus_high_o(bus_hi), .out_voltage_o(volt),
      .out_current_o(cur), .prim_res_o(res), .ramp_tick_o(tick), .bus_hi_i(hi));
   difd_top i_difd_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdata),
      .wb_ack_o(ack), .term_i(term), .dcbus_high_i(bus_hi), .out_voltage_i(volt),
      .out_current_i(cur), .prim_res_i(res), .ramp_tick_i(tick), .func_active_o(func),
      .step_o(step), .preset_sel_o(psel), .freq_cmd_o(freq), .ramp_set_o(ramp),
      .drv_limit_o(drv), .drv_limit_en_o(drv_en), .brk_limit_o(brk), .brk_limit_en_o(brk_en),
      .ov_avoid_o(ovav), .limiting_o(lim), .out_freq_o(outf), .vec_enable_o(vec),
      .eff_boost_o(boost), .slip_comp_on_o(slip_on), .eff_slip_o(slip), .torque_est_o(trq));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // hang guard, well above the expected run length
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   // one classic cycle; read data is taken at the ack edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = rdata;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // longest decode path is seven edges
   task automatic settle;
      repeat (8) @(posedge clk_i);
   endtask
   task automatic summarize;
      if (n_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, tick_en, load, hi} = 6'h00;
      adr = 8'h00;
      wdat = 32'h0;
      contacts = 9'h000;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 9; k++) begin
         bus(0, DIFD_TFUNC_OFS + 8'(4 * k), 16'h0000);
         chk("term_code", 32'(k), rdat);
      end
      bus(0, DIFD_DRV1_OFS, 16'h0000);
      chk("drv1_rst", 32'h3E7, rdat);
      bus(0, 8'h3C, 16'h0000);
      chk("unmapped", 32'h0, rdat);
      chk("drv_en_rst", 32'h0, drv_en);
      // presets, then every step pattern on terminals 1..4
      bus(1, DIFD_FCMD1_OFS, 16'h1234);
      bus(1, DIFD_FCMD2_OFS, 16'h0777);
      for (int k = 1; k < 16; k++) bus(1, DIFD_PRESET_OFS + 8'(4 * k), 16'(100 * k));
      for (int k = 0; k < 16; k++) begin
         contacts <= 9'(k);
         settle();
         chk("step", 32'(k), step);
         chk("presel", 32'(k != 0), psel);
         chk("freq", (k == 0) ? 32'h1234 : 32'(100 * k), freq);
      end
      bus(1, DIFD_PRESET_OFS + 8'h04, 16'hFFFF);
      bus(0, DIFD_PRESET_OFS + 8'h04, 16'h0000);
      chk("preset_clamp", 32'h9C40, rdat);
      for (int r = 0; r < 4; r++) begin
         contacts <= 9'(r << 4);
         settle();
         chk("ramp", 32'(r), ramp);
      end
      // terminal 7 shares code 0 with terminal 1
      bus(1, DIFD_TFUNC_OFS + 8'h18, 16'h0000);
      contacts <= 9'h040;
      settle();
      chk("dup_step", 32'h1, step);
      chk("unassigned", 32'h0, func[20]);
      for (int c = 6; c < 33; c++) begin
         bus(1, DIFD_TFUNC_OFS + 8'h20, 16'(c));
         contacts <= 9'h100;
         settle();
         chk("func", 32'(c != 9), func[c]);
      end
      bus(1, DIFD_TFUNC_OFS + 8'h20, 16'd11);
      settle();
      chk("fsrc2", 32'h0777, freq);
      // limit pairs switched by terminal 9
      bus(1, DIFD_TFUNC_OFS + 8'h20, 16'd14);
      bus(1, DIFD_DRV1_OFS, 16'd150);
      bus(1, DIFD_DRV2_OFS, 16'd50);
      bus(1, DIFD_BRK1_OFS, 16'd0);
      bus(1, DIFD_BRK2_OFS, 16'd10);
      settle();
      chk("drv2", 32'd50, drv);
      chk("brk2_clamp", 32'd20, brk);
      chk("brk2_en", 32'h1, brk_en);
      contacts <= 9'h000;
      settle();
      chk("drv1", 32'd150, drv);
      chk("drv_en", 32'h1, drv_en);
      chk("ov_avoid", 32'h1, ovav);
      chk("brk_en_ov", 32'h0, brk_en);
      bus(1, DIFD_DRV1_OFS, 16'd999);
      settle();
      chk("drv_off", 32'h0, drv_en);
      bus(1, DIFD_BOOST_OFS, 16'h0030);
      settle();
      chk("boost", 32'h30, boost);
      bus(1, DIFD_VEC_OFS, 16'h0001);
      settle();
      chk("vec", 32'h1, vec);
      chk("boost_auto", 32'h0, boost);
      chk("slip_on", 32'h1, slip_on);
      chk("slip_std", 32'(DIFD_STD_SLIP), slip);
      bus(1, DIFD_SLIP_OFS, 16'h0025);
      settle();
      chk("slip_set", 32'h25, slip);
      // ramp to a low command, then overload against a 20 percent limit
      bus(1, DIFD_FCMD1_OFS, 16'd40);
      tick_en <= 1'b1;
      repeat (200) @(posedge clk_i);
      chk("outf", 32'd40, outf);
      bus(1, DIFD_DRV1_OFS, 16'd20);
      load <= 1'b1;
      repeat (60) @(posedge clk_i);
      chk("limiting", 32'h1, lim);
      chk("outf_drop", 32'h1, outf < 16'd40);
      // (400*1000 - (1000*1000>>8)*1) >> 8
      chk("trq", 32'd1547, trq);
      // no load, braking set to 0, bus high: frequency must back up
      load <= 1'b0;
      hi <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk("ov_limit", 32'h1, lim);
      summarize();
   end
endmodule
